// ===== common/lmad_defines.vh
// lmad_defines.vh: constants for the legacy i/o and memory address decoder
// assumes inclusion by bare name from design files under hw/ and from the checker and tb files under sim/
`ifndef LMAD_DEFINES_VH
`define LMAD_DEFINES_VH

// target indices of the one-hot target vector
`define LMAD_T_DMA 5'h00
`define LMAD_T_INTC 5'h01
`define LMAD_T_TMR 5'h02
`define LMAD_T_RTC 5'h03
`define LMAD_T_NMIRTC 5'h04
`define LMAD_T_NMI 5'h05
`define LMAD_T_RSTG 5'h06
`define LMAD_T_FERR 5'h07
`define LMAD_T_PM 5'h08
`define LMAD_T_SATA 5'h09
`define LMAD_T_LPC 5'h0A
`define LMAD_T_SPI 5'h0B
`define LMAD_T_PCI 5'h0C
`define LMAD_T_PCIE 5'h0D
`define LMAD_T_MEM 5'h0E
`define LMAD_T_IOAPIC 5'h0F
`define LMAD_T_RPAPIC 5'h10
`define LMAD_T_SMB 5'h11
`define LMAD_T_GPIO 5'h12
`define LMAD_T_LAN 5'h13
`define LMAD_T_TRAP 5'h14
`define LMAD_T_TCO 5'h15
`define LMAD_T_RSVD 5'h16
`define LMAD_NT 23

// route selects
`define LMAD_R_DMA 2'h0
`define LMAD_R_LPC 2'h1
`define LMAD_R_PCI 2'h2
`define LMAD_R_PCIE 2'h3
`define LMAD_D_SATA 2'h0
`define LMAD_D_PCI 2'h1
`define LMAD_D_PCIE 2'h2
`define LMAD_F_LPC 2'h0
`define LMAD_F_SPI 2'h1
`define LMAD_F_PCI 2'h2

// relocatable i/o window masks (size minus one) and the tco offset from the pm base
`define LMAD_PM_MASK 16'h003F
`define LMAD_TCO_OFS 16'h0060
`define LMAD_TCO_MASK 16'h001F
`define LMAD_SMB_MASK 16'h001F
`define LMAD_GPIO_MASK 16'h007F
`define LMAD_LAN_MASK 16'h001F
`define LMAD_IDEC_MASK 16'h0003
`define LMAD_PER_MASK 16'h0007
`define LMAD_GEN_MIN_MASK 16'h0003
`define LMAD_WIN_MAX_MASK 16'h00FF

// candidate legacy peripheral bases
`define LMAD_PAR0 16'h0378
`define LMAD_PAR1 16'h0278
`define LMAD_PAR2 16'h03BC
`define LMAD_SER0 16'h03F8
`define LMAD_SER1 16'h02F8
`define LMAD_SER2 16'h0220
`define LMAD_SER3 16'h0228
`define LMAD_SER4 16'h0238
`define LMAD_SER5 16'h02E8
`define LMAD_SER6 16'h0338
`define LMAD_SER7 16'h03E8
`define LMAD_FDC0 16'h03F0
`define LMAD_FDC1 16'h0370

// memory map
`define LMAD_LOWMEM_END 32'h000D_FFFF
`define LMAD_HIMEM_BASE 32'h0010_0000
`define LMAD_SEG_E 16'h000E
`define LMAD_SEG_F 16'h000F
`define LMAD_FWE_E 6
`define LMAD_FWE_F 7
`define LMAD_FWE_512K 8
`define LMAD_FW512_TOP 10'h3FF
`define LMAD_FW1M_TOP 10'h3FD
`define LMAD_APIC_TOP 12'hFEC
`define LMAD_APIC_LAST 12'h040
`define LMAD_RP_FIRST 5'h02
`define LMAD_RP_LAST 5'h09
`define LMAD_TPM_TOP 16'hFED4
`define LMAD_ALL_ONES 32'hFFFF_FFFF

`endif

// ===== hw/lmad_win.v
// lmad_win.v: one aligned i/o window compare
// assumes base is aligned to the window size given by the mask
`timescale 1ns/1ps
`default_nettype none
module lmad_win #(
  parameter ADDR_W = 16
) (
  input wire [ADDR_W-1:0] i_addr,
  input wire [ADDR_W-1:0] i_base,
  input wire [ADDR_W-1:0] i_mask,
  input wire i_en,
  output wire o_hit
);
  // low base bits under the mask are ignored, so a misaligned base still yields one window
  assign o_hit = i_en & (((i_addr ^ i_base) & ~i_mask) == {ADDR_W{1'b0}});
endmodule // lmad_win
`default_nettype wire

// ===== hw/lmad_decoder.v
// lmad_decoder.v: routes host i/o and memory cycles to one target each
// assumes configuration inputs come from logic on i_sys_clk, held stable
`timescale 1ns/1ps
`default_nettype none
`include "lmad_defines.vh"
module lmad_decoder #(
  parameter NGEN = 4
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_cyc_valid,
  input wire i_cyc_mem,
  input wire i_cyc_wr,
  input wire [31:0] i_addr,
  input wire [1:0] i_dbg_route,
  input wire [1:0] i_disk_route,
  input wire [1:0] i_fw_route,
  input wire [15:0] i_pm_base,
  input wire i_pm_en,
  input wire [15:0] i_smb_base,
  input wire i_smb_en,
  input wire [15:0] i_gpio_base,
  input wire i_gpio_en,
  input wire [15:0] i_lan_base,
  input wire i_lan_en,
  input wire [15:0] i_idec_base,
  input wire i_idec_en,
  input wire [1:0] i_par_sel,
  input wire i_par_en,
  input wire [2:0] i_ser1_sel,
  input wire i_ser1_en,
  input wire [2:0] i_ser2_sel,
  input wire i_ser2_en,
  input wire i_fdc_sel,
  input wire i_fdc_en,
  input wire [16*NGEN-1:0] i_gen_base,
  input wire [8*NGEN-1:0] i_gen_mask,
  input wire [NGEN-1:0] i_gen_en,
  input wire [15:0] i_trap_base,
  input wire [7:0] i_trap_mask,
  input wire i_trap_en,
  input wire [14:0] i_fw_decode_en,
  input wire [31:0] i_top_of_memory_limit,
  input wire [7:0] i_apic_window_select_field,
  input wire i_apic_window_enable_bit,
  input wire [7:0] i_root_port_apic_enable,
  input wire [15:0] i_lpc_mem_base,
  input wire [31:0] i_lpc_mem_ctl,
  output wire [`LMAD_NT-1:0] o_tgt,
  output wire [2:0] o_rp_port,
  output wire o_rd_all_ones,
  output reg [`LMAD_NT-1:0] o_tgt_ff,
  output reg [2:0] o_rp_port_ff,
  output reg [31:0] o_rd_data_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // relocatable i/o windows

  wire [15:0] a = i_addr[15:0];
  wire [15:0] tco_base = i_pm_base + `LMAD_TCO_OFS;
  reg [15:0] par_base;
  reg [15:0] ser1_base;
  reg [15:0] ser2_base;
  wire [15:0] fdc_base = i_fdc_sel ? `LMAD_FDC1 : `LMAD_FDC0;
  wire hit_pm;
  wire hit_tco;
  wire hit_smb;
  wire hit_gpio;
  wire hit_lan;
  wire hit_idec;
  wire hit_par;
  wire hit_ser1;
  wire hit_ser2;
  wire hit_fdc;
  wire hit_trap;
  wire [NGEN-1:0] hit_gen;

  function [15:0] ser_base;
    input [2:0] s;
    begin
      case (s)
        3'h0: ser_base = `LMAD_SER0;
        3'h1: ser_base = `LMAD_SER1;
        3'h2: ser_base = `LMAD_SER2;
        3'h3: ser_base = `LMAD_SER3;
        3'h4: ser_base = `LMAD_SER4;
        3'h5: ser_base = `LMAD_SER5;
        3'h6: ser_base = `LMAD_SER6;
        default: ser_base = `LMAD_SER7;
      endcase
    end
  endfunction

  always @*
  begin
    ser1_base = ser_base(i_ser1_sel);
    ser2_base = ser_base(i_ser2_sel);
    case (i_par_sel)
      2'h0: par_base = `LMAD_PAR0;
      2'h1: par_base = `LMAD_PAR1;
      default: par_base = `LMAD_PAR2;
    endcase
  end

  lmad_win #(.ADDR_W(16)) u_pm (.i_addr(a), .i_base(i_pm_base),
    .i_mask(`LMAD_PM_MASK), .i_en(i_pm_en), .o_hit(hit_pm));
  lmad_win #(.ADDR_W(16)) u_tco (.i_addr(a), .i_base(tco_base),
    .i_mask(`LMAD_TCO_MASK), .i_en(i_pm_en), .o_hit(hit_tco));
  lmad_win #(.ADDR_W(16)) u_smb (.i_addr(a), .i_base(i_smb_base),
    .i_mask(`LMAD_SMB_MASK), .i_en(i_smb_en), .o_hit(hit_smb));
  lmad_win #(.ADDR_W(16)) u_gpio (.i_addr(a), .i_base(i_gpio_base),
    .i_mask(`LMAD_GPIO_MASK), .i_en(i_gpio_en), .o_hit(hit_gpio));
  lmad_win #(.ADDR_W(16)) u_lan (.i_addr(a), .i_base(i_lan_base),
    .i_mask(`LMAD_LAN_MASK), .i_en(i_lan_en), .o_hit(hit_lan));
  lmad_win #(.ADDR_W(16)) u_idec (.i_addr(a), .i_base(i_idec_base),
    .i_mask(`LMAD_IDEC_MASK), .i_en(i_idec_en), .o_hit(hit_idec));
  lmad_win #(.ADDR_W(16)) u_par (.i_addr(a), .i_base(par_base),
    .i_mask(`LMAD_PER_MASK), .i_en(i_par_en), .o_hit(hit_par));
  lmad_win #(.ADDR_W(16)) u_ser1 (.i_addr(a), .i_base(ser1_base),
    .i_mask(`LMAD_PER_MASK), .i_en(i_ser1_en), .o_hit(hit_ser1));
  lmad_win #(.ADDR_W(16)) u_ser2 (.i_addr(a), .i_base(ser2_base),
    .i_mask(`LMAD_PER_MASK), .i_en(i_ser2_en), .o_hit(hit_ser2));
  lmad_win #(.ADDR_W(16)) u_fdc (.i_addr(a), .i_base(fdc_base),
    .i_mask(`LMAD_PER_MASK), .i_en(i_fdc_en), .o_hit(hit_fdc));
  // trap windows may be a single byte, so the mask has no floor
  lmad_win #(.ADDR_W(16)) u_trap (.i_addr(a), .i_base(i_trap_base),
    .i_mask({8'h00, i_trap_mask}), .i_en(i_trap_en), .o_hit(hit_trap));

  genvar g;
  generate
    for (g = 0; g < NGEN; g = g + 1)
    begin : g_gen
      // generic windows never shrink below four bytes
      lmad_win #(.ADDR_W(16)) u_gen (.i_addr(a), .i_base(i_gen_base[16*g +: 16]),
        .i_mask({8'h00, i_gen_mask[8*g +: 8]} | `LMAD_GEN_MIN_MASK),
        .i_en(i_gen_en[g]), .o_hit(hit_gen[g]));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // fixed i/o decode

  wire [7:0] b = a[7:0];
  wire lo = (a[15:8] == 8'h00);
  reg [4:0] io_sel;
  reg io_hit;
  reg [4:0] dbg_tgt;
  reg [4:0] disk_tgt;

  always @*
  begin
    case (i_dbg_route)
      `LMAD_R_LPC: dbg_tgt = `LMAD_T_LPC;
      `LMAD_R_PCI: dbg_tgt = `LMAD_T_PCI;
      `LMAD_R_PCIE: dbg_tgt = `LMAD_T_PCIE;
      default: dbg_tgt = `LMAD_T_DMA;
    endcase
    case (i_disk_route)
      `LMAD_D_PCI: disk_tgt = `LMAD_T_PCI;
      `LMAD_D_PCIE: disk_tgt = `LMAD_T_PCIE;
      default: disk_tgt = `LMAD_T_SATA;
    endcase
  end

  // priority: trap, fixed legacy, then relocatable windows; unclaimed goes to pci
  always @*
  begin
    io_hit = 1'b1;
    io_sel = `LMAD_T_PCI;
    if (hit_trap)
      io_sel = `LMAD_T_TRAP;
    else if (lo && ((b <= 8'h08) || b == 8'h0F || (b >= 8'h10 && b <= 8'h18) ||
        b == 8'h1F))
      io_sel = `LMAD_T_DMA;
    else if (lo && ((b >= 8'h09 && b <= 8'h0E) || (b >= 8'h19 && b <= 8'h1E)))
      io_sel = i_cyc_wr ? `LMAD_T_DMA : `LMAD_T_RSVD;
    else if (lo && (b == 8'h2E || b == 8'h2F || b == 8'h4E || b == 8'h4F))
      io_sel = `LMAD_T_LPC;
    else if (lo && !b[1] && ((b >= 8'h20 && b <= 8'h3F) || (b >= 8'hA0 && b <= 8'hBF)))
      io_sel = `LMAD_T_INTC;
    else if (a == 16'h04D0 || a == 16'h04D1)
      io_sel = `LMAD_T_INTC;
    else if (lo && ((b >= 8'h40 && b <= 8'h42) || (b >= 8'h50 && b <= 8'h52)))
      io_sel = `LMAD_T_TMR;
    else if (lo && (b == 8'h43 || b == 8'h53))
      io_sel = i_cyc_wr ? `LMAD_T_TMR : `LMAD_T_RSVD;
    else if (lo && (b == 8'h60 || b == 8'h62 || b == 8'h64 || b == 8'h66))
      io_sel = `LMAD_T_LPC;
    else if (lo && b == 8'h61)
      io_sel = `LMAD_T_NMI;
    else if (lo && b == 8'h70)
      io_sel = i_cyc_wr ? `LMAD_T_NMIRTC : `LMAD_T_RSVD;
    else if (lo && b >= 8'h71 && b <= 8'h77)
      io_sel = (i_cyc_wr && !b[0]) ? `LMAD_T_NMIRTC : `LMAD_T_RTC;
    else if (lo && b == 8'h80)
      io_sel = dbg_tgt;
    else if (lo && ((b >= 8'h84 && b <= 8'h86) || b == 8'h88 ||
        (b >= 8'h8C && b <= 8'h8E)))
      io_sel = i_cyc_wr ? dbg_tgt : `LMAD_T_DMA;
    else if ((lo && b == 8'h92) || a == 16'h0CF9)
      io_sel = `LMAD_T_RSTG;
    else if (lo && ((b >= 8'h81 && b <= 8'h9F) || (b >= 8'hC0 && b <= 8'hD1) ||
        b == 8'hDE || b == 8'hDF))
      io_sel = `LMAD_T_DMA;
    else if (lo && b >= 8'hD2 && b <= 8'hDD)
      io_sel = i_cyc_wr ? `LMAD_T_DMA : `LMAD_T_RSVD;
    else if (lo && b == 8'hF0)
      io_sel = `LMAD_T_FERR;
    else if (lo && (b == 8'hB2 || b == 8'hB3))
      io_sel = `LMAD_T_PM;
    else if ((a[15:3] == 13'h002E) || (a[15:3] == 13'h003E) || a == 16'h0376 ||
        a == 16'h03F6)
      io_sel = disk_tgt;
    else if (a[15:4] == 12'h020)
      io_sel = `LMAD_T_LPC;
    else if (hit_pm)
      io_sel = `LMAD_T_PM;
    else if (hit_tco)
      io_sel = `LMAD_T_TCO;
    else if (hit_smb)
      io_sel = `LMAD_T_SMB;
    else if (hit_gpio)
      io_sel = `LMAD_T_GPIO;
    else if (hit_lan)
      io_sel = `LMAD_T_LAN;
    else if (hit_idec)
      io_sel = disk_tgt;
    else if (hit_par || hit_ser1 || hit_ser2 || hit_fdc || (|hit_gen))
      io_sel = `LMAD_T_LPC;
    else
      io_hit = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory decode

  reg [4:0] fw_tgt;
  reg [4:0] mem_sel;
  reg [2:0] rp_port;
  wire [4:0] rp_idx = i_addr[19:15] - `LMAD_RP_FIRST;
  wire [2:0] fw512_idx = i_addr[21:19];
  wire [3:0] fw512_bit = {1'b0, fw512_idx} + 4'h8;
  wire fw512_on = (fw512_idx == 3'h7) | i_fw_decode_en[fw512_bit];

  always @*
  begin
    case (i_fw_route)
      `LMAD_F_SPI: fw_tgt = `LMAD_T_SPI;
      `LMAD_F_PCI: fw_tgt = `LMAD_T_PCI;
      default: fw_tgt = `LMAD_T_LPC;
    endcase
  end

  always @*
  begin
    mem_sel = `LMAD_T_PCI;
    rp_port = 3'h0;
    if (i_addr <= `LMAD_LOWMEM_END)
      mem_sel = `LMAD_T_MEM;
    else if (i_addr[31:16] == `LMAD_SEG_E && i_fw_decode_en[`LMAD_FWE_E])
      // an enabled low segment never goes to pci, even on the pci route
      mem_sel = (i_fw_route == `LMAD_F_SPI) ? `LMAD_T_SPI : `LMAD_T_LPC;
    else if (i_addr[31:16] == `LMAD_SEG_F && i_fw_decode_en[`LMAD_FWE_F])
      mem_sel = (i_fw_route == `LMAD_F_SPI) ? `LMAD_T_SPI : `LMAD_T_LPC;
    else if (i_addr >= `LMAD_HIMEM_BASE && i_addr < i_top_of_memory_limit)
      mem_sel = `LMAD_T_MEM;
    else if (i_addr[31:22] == `LMAD_FW512_TOP && fw512_on)
      mem_sel = fw_tgt;
    else if (i_addr[31:22] == `LMAD_FW1M_TOP && i_fw_decode_en[i_addr[21:20]])
      mem_sel = fw_tgt;
    else if (i_addr[31:20] == `LMAD_APIC_TOP && i_apic_window_enable_bit &&
        i_addr[19:12] == i_apic_window_select_field && i_addr[11:0] <= `LMAD_APIC_LAST)
      mem_sel = `LMAD_T_IOAPIC;
    else if (i_addr[31:20] == `LMAD_APIC_TOP && i_addr[19:15] >= `LMAD_RP_FIRST &&
        i_addr[19:15] <= `LMAD_RP_LAST && i_root_port_apic_enable[rp_idx[2:0]])
    begin
      mem_sel = `LMAD_T_RPAPIC;
      rp_port = rp_idx[2:0];
    end
    else if (i_addr[31:16] == `LMAD_TPM_TOP)
      mem_sel = `LMAD_T_LPC;
    else if (i_lpc_mem_ctl[0] && i_addr[31:16] == i_lpc_mem_base)
      mem_sel = `LMAD_T_LPC;
  end

  ////////////////////////////////////////////////////////////////////////////
  // target select and capture

  wire [4:0] sel = i_cyc_mem ? mem_sel : (io_hit ? io_sel : `LMAD_T_PCI);
  wire [`LMAD_NT-1:0] one = {{(`LMAD_NT-1){1'b0}}, 1'b1};

  // exactly one bit while a cycle is presented, none otherwise
  assign o_tgt = i_cyc_valid ? (one << sel) : {`LMAD_NT{1'b0}};
  assign o_rp_port = (i_cyc_valid && i_cyc_mem) ? rp_port : 3'h0;
  // a reserved read reaches no unit, so it cannot cause a side effect
  assign o_rd_all_ones = i_cyc_valid && !i_cyc_wr &&
    (sel == `LMAD_T_RSVD);

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_tgt_ff <= {`LMAD_NT{1'b0}};
      o_rp_port_ff <= 3'h0;
      o_rd_data_ff <= 32'h0000_0000;
    end
    else if (i_cyc_valid)
    begin
      o_tgt_ff <= o_tgt;
      o_rp_port_ff <= o_rp_port;
      o_rd_data_ff <= o_rd_all_ones ? `LMAD_ALL_ONES : 32'h0000_0000;
    end
  end

endmodule // lmad_decoder
`default_nettype wire

// ===== sim/lmad_decoder_assertions.sv
// lmad_decoder_assertions.sv: port-level checks of the address decoder
// assumes it is bound onto lmad_decoder, one clock, sync active-high reset
`timescale 1ns/1ps
`default_nettype none
`include "lmad_defines.vh"
module lmad_chk (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_cyc_valid,
  input wire logic i_cyc_mem,
  input wire logic i_cyc_wr,
  input wire logic [31:0] i_addr,
  input wire logic i_trap_en,
  input wire logic [7:0] i_root_port_apic_enable,
  input wire logic [`LMAD_NT-1:0] o_tgt,
  input wire logic [2:0] o_rp_port,
  input wire logic o_rd_all_ones,
  input wire logic [`LMAD_NT-1:0] o_tgt_ff,
  input wire logic [31:0] o_rd_data_ff
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // a trap window outranks the fixed map, so fixed-map checks need it off
  wire io_rd = i_cyc_valid && !i_cyc_mem && !i_cyc_wr && !i_trap_en;
  wire io_wr = i_cyc_valid && !i_cyc_mem && i_cyc_wr && !i_trap_en;
  wire mem = i_cyc_valid && i_cyc_mem;
  wire [4:0] rp_idx = i_addr[19:15] - 5'h02;
  ////////////////////////////////////////
  sequence s_ones_out;
    o_rd_all_ones && o_tgt[`LMAD_T_RSVD] ##1 o_rd_data_ff == 32'hFFFF_FFFF;
  endsequence
  one_target_a: assert property (i_cyc_valid |-> $onehot(o_tgt))
    else $error("target not one-hot");
  idle_quiet_a: assert property (!i_cyc_valid |-> o_tgt == 0 && !o_rd_all_ones)
    else $error("target set without a cycle");
  capture_tgt_a: assert property (i_cyc_valid |=> o_tgt_ff == $past(o_tgt))
    else $error("registered target differs");
  hold_tgt_a: assert property (!i_cyc_valid |=> $stable(o_tgt_ff))
    else $error("registered target moved while idle");
  rsvd_read_a: assert property (io_rd && i_addr[15:0] inside {16'h0009, 16'h0043,
    16'h0070, 16'h00D2} |-> s_ones_out) else $error("reserved read not all ones");
  wo_dma_a: assert property (io_wr && i_addr[15:0] inside {16'h0009, 16'h001E,
    16'h00D2, 16'h00DD} |-> o_tgt[`LMAD_T_DMA]) else $error("write-only dma missed");
  rtc_split_a: assert property (io_wr && i_addr[15:0] inside {16'h0070, 16'h0072,
    16'h0074, 16'h0076} |-> o_tgt[`LMAD_T_NMIRTC]) else $error("even rtc write missed");
  fw_top_a: assert property (mem && i_addr[31:19] == 13'h1FFF |->
    o_tgt[`LMAD_T_LPC] || o_tgt[`LMAD_T_SPI] || o_tgt[`LMAD_T_PCI])
    else $error("top firmware window not decoded");
  rp_apic_a: assert property (mem && i_addr[31:20] == 12'hFEC && rp_idx < 5'h08 &&
    i_addr[11:0] == 12'hF00 && i_root_port_apic_enable[rp_idx[2:0]] |->
    o_tgt[`LMAD_T_RPAPIC] && o_rp_port == rp_idx[2:0]) else $error("root port apic wrong");
  ones_cause_a: assert property (o_rd_all_ones |-> i_cyc_valid && !i_cyc_wr &&
    o_tgt[`LMAD_T_RSVD]) else $error("all ones without reserved read");
  lowmem_a: assert property (mem && i_addr <= 32'h000D_FFFF |-> o_tgt[`LMAD_T_MEM])
    else $error("low memory not to main memory");
endmodule // lmad_chk
bind lmad_decoder lmad_chk lmad_chk_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_cyc_valid(i_cyc_valid), .i_cyc_mem(i_cyc_mem), .i_cyc_wr(i_cyc_wr), .i_addr(i_addr),
  .i_trap_en(i_trap_en), .i_root_port_apic_enable(i_root_port_apic_enable), .o_tgt(o_tgt),
  .o_rp_port(o_rp_port), .o_rd_all_ones(o_rd_all_ones), .o_tgt_ff(o_tgt_ff),
  .o_rd_data_ff(o_rd_data_ff));
`default_nettype wire

// ===== sim/lmad_host.sv
// lmad_host.sv: host bus model issuing one i/o or memory cycle per clock
// assumes its tasks are called just after a falling clock edge
`timescale 1ns/1ps
`default_nettype none
module lmad_host (
  output logic o_valid,
  output logic o_mem,
  output logic o_wr,
  output logic [31:0] o_addr
);
  initial
  begin
    o_valid = 1'b0;
    o_mem = 1'b0;
    o_wr = 1'b0;
    o_addr = 32'h0000_0000;
  end
  task automatic cyc(input logic mem, input logic wr, input logic [31:0] a);
    begin
      o_valid = 1'b1;
      o_mem = mem;
      o_wr = wr;
      o_addr = a;
    end
  endtask
  // released address shows its inverse so nothing can lean on a stale value
  task automatic idle;
    begin
      o_valid = 1'b0;
      o_addr = ~o_addr;
    end
  endtask
endmodule // lmad_host
`default_nettype wire

// ===== sim/legacy_io_memory_address_decoder_tb_top.sv
// tb top: directed decode scenarios through a host cycle model
// assumes decoder, checker bind and host model are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "lmad_defines.vh"
module legacy_io_memory_address_decoder_tb_top;
  // starting low avoids an x-to-0 edge at time zero that would shorten the first reset
  logic clk = 1'b0;
  logic rst, cv, cm, cw, pme, sme, gpe, lne, ide, root_port_apic_enable, s1e, s2e, fds, fde, te, apic_window_enable_bit, ones;
  logic [1:0] dbg, dsk, fwr, psl;
  logic [2:0] s1, s2, rpo, rpf;
  logic [3:0] ge;
  logic [7:0] tm, asl, rpe;
  logic [14:0] fwe;
  logic [15:0] pmb, smb, gpb, lnb, idb, tbs, lmb;
  logic [31:0] ca, top_of_memory_limit, lmc, gm, rdd;
  logic [63:0] gb;
  logic [22:0] tg, tgf;
  int num_errors = 0;
  int checks = 0;
  // rows are write flag, i/o address, expected target index
  logic [23:0] fix [33] = '{24'h000800, 24'h000916, 24'h100900, 24'h001E16, 24'h001F00,
    24'h002C01, 24'h10BD01, 24'h04D101, 24'h00220C, 24'h102F0A, 24'h004E0A, 24'h004202,
    24'h004316, 24'h105302, 24'h00660A, 24'h106105, 24'h007016, 24'h107004, 24'h007203,
    24'h107204, 24'h107703, 24'h009206, 24'h1CF906, 24'h00D100, 24'h10DD00, 24'h009F00,
    24'h108F00, 24'h00F007, 24'h10B308, 24'h020F0A, 24'h12000A, 24'h00B208, 24'h00D216};
  logic [4:0] rt [4] = '{`LMAD_T_DMA, `LMAD_T_LPC, `LMAD_T_PCI, `LMAD_T_PCIE};
  logic [4:0] dk [4] = '{`LMAD_T_SATA, `LMAD_T_PCI, `LMAD_T_PCIE, `LMAD_T_SATA};
  logic [15:0] sb [8] = '{`LMAD_SER0, `LMAD_SER1, `LMAD_SER2, `LMAD_SER3, `LMAD_SER4,
    `LMAD_SER5, `LMAD_SER6, `LMAD_SER7};
  lmad_host lmad_host_i (.o_valid(cv), .o_mem(cm), .o_wr(cw), .o_addr(ca));
  lmad_decoder #(.NGEN(4)) lmad_decoder_i (
    .i_sys_clk(clk), .i_rst(rst), .i_cyc_valid(cv), .i_cyc_mem(cm), .i_cyc_wr(cw),
    .i_addr(ca), .i_dbg_route(dbg), .i_disk_route(dsk), .i_fw_route(fwr),
    .i_pm_base(pmb), .i_pm_en(pme), .i_smb_base(smb), .i_smb_en(sme),
    .i_gpio_base(gpb), .i_gpio_en(gpe), .i_lan_base(lnb), .i_lan_en(lne),
    .i_idec_base(idb), .i_idec_en(ide), .i_par_sel(psl), .i_par_en(root_port_apic_enable),
    .i_ser1_sel(s1), .i_ser1_en(s1e), .i_ser2_sel(s2), .i_ser2_en(s2e),
    .i_fdc_sel(fds), .i_fdc_en(fde), .i_gen_base(gb), .i_gen_mask(gm), .i_gen_en(ge),
    .i_trap_base(tbs), .i_trap_mask(tm), .i_trap_en(te), .i_fw_decode_en(fwe),
    .i_top_of_memory_limit(top_of_memory_limit), .i_apic_window_select_field(asl),
    .i_apic_window_enable_bit(apic_window_enable_bit), .i_root_port_apic_enable(rpe),
    .i_lpc_mem_base(lmb), .i_lpc_mem_ctl(lmc), .o_tgt(tg), .o_rp_port(rpo),
    .o_rd_all_ones(ones), .o_tgt_ff(tgf), .o_rp_port_ff(rpf), .o_rd_data_ff(rdd));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    begin
      checks++;
      if (got !== exp)
      begin
        num_errors++;
        $display("[FAIL] %0t %s got %0h expected %0h", $time, what, got, exp);
      end
    end
  endtask
  task automatic end_sim;
    begin
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // one cycle: comb answer in its own cycle, registered copy after the edge
  task automatic go(input logic mem, input logic wr, input logic [31:0] a, input logic [4:0] t);
    logic [22:0] e;
    begin
      e = 23'h000001 << t;
      lmad_host_i.cyc(mem, wr, a);
      #1;
      cmp(tg, e, "target");
      cmp(ones, t == `LMAD_T_RSVD, "all_ones");
      @(posedge clk);
      #1;
      cmp(tgf, e, "target_ff");
      cmp(rdd, (t == `LMAD_T_RSVD) ? 32'hFFFF_FFFF : 32'h0000_0000, "read_data");
      @(negedge clk);
    end
  endtask
  // upper address bits are junk on purpose: i/o decode must ignore them
  task automatic io(input logic wr, input logic [15:0] a, input logic [4:0] t);
    go(1'b0, wr, {16'hA5A5, a}, t);
  endtask
  task automatic mm(input logic [31:0] a, input logic [4:0] t);
    go(1'b1, 1'b0, a, t);
  endtask
  ////////////////////////////////////////
  task automatic t_reset(input int n);
    begin
      lmad_host_i.idle();
      rst = 1'b1;
      repeat (n) @(negedge clk);
      rst = 1'b0;
      cmp(tgf, 32'h0, "target_ff_reset");
      cmp(rdd, 32'h0, "read_data_reset");
      cmp(rpf, 32'h0, "port_ff_reset");
    end
  endtask
  task automatic t_fixed;
    foreach (fix[k])
      io(fix[k][20], fix[k][19:8], fix[k][4:0]);
  endtask
  task automatic t_steer;
    for (int r = 0; r < 4; r++)
    begin
      dbg = r[1:0];
      dsk = r[1:0];
      io(1'b0, 16'h0080, rt[r]);
      io(1'b1, 16'h008E, rt[r]);
      io(1'b0, 16'h0085, `LMAD_T_DMA);
      io(1'b1, 16'h0376, dk[r]);
      io(1'b0, 16'h01F0, dk[r]);
    end
  endtask
  task automatic t_reloc;
    begin
      io(1'b1, 16'h103F, `LMAD_T_PM);
      io(1'b0, 16'h1060, `LMAD_T_TCO);
      io(1'b0, 16'h107F, `LMAD_T_TCO);
      io(1'b0, 16'h1080, `LMAD_T_PCI);
      io(1'b0, 16'h201F, `LMAD_T_SMB);
      io(1'b1, 16'h20FF, `LMAD_T_GPIO);
      io(1'b0, 16'h211F, `LMAD_T_LAN);
      io(1'b0, 16'h2123, `LMAD_T_SATA);
      io(1'b0, 16'h2124, `LMAD_T_PCI);
      // second serial window off, so each first-window candidate stands alone
      s2e = 1'b0;
      for (int s = 0; s < 8; s++)
      begin
        s1 = s[2:0];
        io(1'b0, sb[s] + 16'h0007, `LMAD_T_LPC);
      end
      io(1'b0, 16'h037F, `LMAD_T_LPC);
      io(1'b0, 16'h03F0, `LMAD_T_LPC);
      psl = 2'h1;
      io(1'b1, 16'h0278, `LMAD_T_LPC);
      root_port_apic_enable = 1'b0;
      io(1'b0, 16'h0278, `LMAD_T_PCI);
      root_port_apic_enable = 1'b1;
      s2e = 1'b1;
      psl = 2'h2;
      s2 = 3'h5;
      fds = 1'b1;
      io(1'b1, 16'h03BC, `LMAD_T_LPC);
      io(1'b0, 16'h02EF, `LMAD_T_LPC);
      io(1'b0, 16'h0370, `LMAD_T_LPC);
      io(1'b0, 16'h300F, `LMAD_T_LPC);
      io(1'b0, 16'h3010, `LMAD_T_PCI);
      io(1'b1, 16'h3103, `LMAD_T_LPC);
      io(1'b0, 16'h3104, `LMAD_T_PCI);
      te = 1'b1;
      io(1'b0, 16'h4000, `LMAD_T_TRAP);
      io(1'b0, 16'h4001, `LMAD_T_PCI);
      te = 1'b0;
      pme = 1'b0;
      io(1'b0, 16'h1000, `LMAD_T_PCI);
    end
  endtask
  task automatic t_fw;
    begin
      mm(32'h000D_FFFF, `LMAD_T_MEM);
      mm(32'h0FFF_FFFF, `LMAD_T_MEM);
      mm(32'h1000_0000, `LMAD_T_PCI);
      mm(32'h000E_0000, `LMAD_T_PCI);
      fwe = 15'h0040;
      mm(32'h000E_FFFF, `LMAD_T_LPC);
      mm(32'h000F_0000, `LMAD_T_PCI);
      fwe = 15'h0080;
      fwr = 2'h1;
      mm(32'h000F_FFFF, `LMAD_T_SPI);
      fwe = 15'h0000;
      fwr = 2'h2;
      mm(32'hFFF8_0000, `LMAD_T_PCI);
      fwr = 2'h3;
      mm(32'hFFFF_FFFF, `LMAD_T_LPC);
      fwr = 2'h0;
      for (int k = 0; k < 7; k++)
      begin
        fwe = 15'h0000;
        mm(32'hFFC0_0000 + (k << 19), `LMAD_T_PCI);
        fwe[8 + k] = 1'b1;
        mm(32'hFFC7_FFFF + (k << 19), `LMAD_T_LPC);
      end
      fwr = 2'h1;
      for (int k = 0; k < 4; k++)
      begin
        fwe = 15'h0000;
        mm(32'hFF40_0000 + (k << 20), `LMAD_T_PCI);
        fwe[k] = 1'b1;
        mm(32'hFF4F_FFFF + (k << 20), `LMAD_T_SPI);
      end
    end
  endtask
  task automatic t_apic;
    begin
      asl = 8'h20;
      mm(32'hFEC2_0000, `LMAD_T_PCI);
      apic_window_enable_bit = 1'b1;
      mm(32'hFEC2_0040, `LMAD_T_IOAPIC);
      mm(32'hFEC2_0041, `LMAD_T_PCI);
      for (int n = 0; n < 8; n++)
      begin
        rpe = 8'h00;
        mm(32'hFEC1_0F00 + (n << 15), `LMAD_T_PCI);
        rpe = 8'h01 << n;
        mm(32'hFEC1_7F00 + (n << 15), `LMAD_T_RPAPIC);
        cmp(rpo, n, "port");
        cmp(rpf, n, "port_ff");
      end
    end
  endtask
  task automatic t_lpcmem;
    begin
      mm(32'hFED4_0000, `LMAD_T_LPC);
      mm(32'hFED4_FFFF, `LMAD_T_LPC);
      mm(32'h8000_1234, `LMAD_T_PCI);
      lmc = 32'hFFFF_FFFE;
      mm(32'h8000_0000, `LMAD_T_PCI);
      lmc = 32'h0000_0001;
      mm(32'h8000_FFFF, `LMAD_T_LPC);
      mm(32'h8001_0000, `LMAD_T_PCI);
    end
  endtask
  // no cycle after the last memory test: nothing selected, registered copies keep the last cycle
  task automatic t_idle;
    begin
      lmad_host_i.idle();
      #1;
      cmp(tg, 23'h0, "idle_target");
      cmp(ones, 1'b0, "idle_all_ones");
      repeat (2) @(posedge clk);
      #1;
      cmp(tgf, 23'h000001 << `LMAD_T_PCI, "idle_target_ff");
      cmp(rdd, 32'h0, "idle_read_data");
      @(negedge clk);
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    {rst, pme, sme, gpe, lne, ide, root_port_apic_enable, s1e, s2e, fde, ge} = {10'h3FF, 4'h3};
    {dbg, dsk, fwr, psl, s1, s2, fds, te, tm, apic_window_enable_bit, asl, rpe, fwe, lmc} = 88'h0;
    {pmb, smb, gpb, lnb, idb, tbs, lmb} = {16'h1000, 16'h2000, 16'h2080, 16'h2100,
      16'h2120, 16'h4000, 16'h8000};
    gb = {32'h0000_0000, 16'h3100, 16'h3000};
    gm = 32'h0000_000F;
    top_of_memory_limit = 32'h1000_0000;
    t_reset(16);
    t_fixed;
    t_reset(2);
    t_steer;
    t_reloc;
    t_fw;
    t_apic;
    t_lpcmem;
    t_idle;
    end_sim;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("[FAIL] %0t run did not finish", $time);
    end_sim;
  end
endmodule // legacy_io_memory_address_decoder_tb_top
`default_nettype wire
